// ===== rtl/pcs_pkg.sv
// constants, register map and state encoding for the power cycle sequencer
package pcs_pkg;

   // register port geometry
   localparam int PCS_ADDR_W = 8;
   localparam int PCS_DATA_W = 16;

   // control and monitor register indexes
   localparam logic [7:0] PCS_IDX_MODE = 8'h24;
   localparam logic [7:0] PCS_IDX_WAIT = 8'h25;
   localparam logic [7:0] PCS_IDX_OFF = 8'h26;
   localparam logic [7:0] PCS_IDX_UPDLY = 8'h27;
   localparam logic [7:0] PCS_IDX_IN_MV = 8'h91;
   localparam logic [7:0] PCS_IDX_IN_MA = 8'h92;
   localparam logic [7:0] PCS_IDX_BAT_MV = 8'h93;
   localparam logic [7:0] PCS_IDX_CHG_MA = 8'h94;

   // mode register fields
   localparam int PCS_MODE_ARM_BIT = 0;
   localparam int PCS_MODE_UPALW_BIT = 1;
   localparam logic [1:0] PCS_MODE_MASK = 2'h3;

   // reset values
   localparam logic [15:0] PCS_MODE_RST = 16'h0000;
   localparam logic [15:0] PCS_WAIT_RST = 16'h003C;
   localparam logic [15:0] PCS_OFF_RST = 16'h0005;
   localparam logic [15:0] PCS_UPDLY_RST = 16'h0000;
   localparam logic [15:0] PCS_ZERO = 16'h0000;
   localparam logic [15:0] PCS_ONE = 16'h0001;

   // timing: one-second tick from the 40 MHz core clock
   localparam longint PCS_CLK_HZ = 40_000_000;
   localparam longint PCS_TICK_PERIOD_S = 1;
   localparam int PCS_TICK_CYCLES = int'(PCS_TICK_PERIOD_S * PCS_CLK_HZ);

   // sequencer states, gray along idle-arm-wait-off
   typedef enum logic [2:0]
   {
      PCS_S_UP = 3'h0,
      PCS_S_IDLE = 3'h1,
      PCS_S_ARMED = 3'h3,
      PCS_S_WAIT = 3'h2,
      PCS_S_OFF = 3'h6
   } pcs_state_type;

endpackage : pcs_pkg

// ===== rtl/pcs_sync.sv
// two-flop synchroniser for the asynchronous pin inputs
module pcs_sync
   import pcs_pkg::*;
#(
   parameter int WIDTH = 3
)
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         always_ff @(posedge core_clk)
         begin
            if (!rst_b)
            begin
               meta_q[i] <= 1'b0;
               sync_out[i] <= 1'b0;
            end
            else
            begin
               meta_q[i] <= async_in[i];
               sync_out[i] <= meta_q[i];
            end
         end
      end
   endgenerate

endmodule : pcs_sync

// ===== rtl/pcs_tick.sv
// one-cycle pulse every tick_cycles clock cycles
module pcs_tick
   import pcs_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = PCS_TICK_CYCLES
)
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic restart,
   output logic tick
);

   localparam int CW = $clog2(TICK_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

   logic [CW-1:0] cnt_q;

   always_ff @(posedge core_clk)
   begin
      if (!rst_b || restart)
      begin
         cnt_q <= '0;
         tick <= 1'b0;
      end
      else if (cnt_q == LAST)
      begin
         cnt_q <= '0;
         tick <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + CW'(1);
         tick <= 1'b0;
      end
   end

endmodule : pcs_tick

// ===== rtl/pcs_top.sv
// delayed power cycle sequencer with its control and monitor registers
module pcs_top
   import pcs_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = PCS_TICK_CYCLES
)
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic shutdown_request_line,
   input wire logic main_power_present,
   input wire logic watchdog_enable,
   input wire logic [PCS_ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [PCS_DATA_W-1:0] reg_wdata,
   output logic [PCS_DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic [PCS_DATA_W-1:0] input_mv,
   input wire logic [PCS_DATA_W-1:0] input_ma,
   input wire logic [PCS_DATA_W-1:0] battery_mv,
   input wire logic [PCS_DATA_W-1:0] charge_ma,
   output logic host_power_en,
   output logic host_run,
   output logic usb_power_en,
   output logic unit_power_en,
   output logic watchdog_hold,
   output logic cycle_active
);

   // control registers
   logic [PCS_DATA_W-1:0] mode_q;
   logic [PCS_DATA_W-1:0] wait_s_q;
   logic [PCS_DATA_W-1:0] off_s_q;
   logic [PCS_DATA_W-1:0] updly_s_q;

   // captured monitor readings
   logic [PCS_DATA_W-1:0] in_mv_q;
   logic [PCS_DATA_W-1:0] in_ma_q;
   logic [PCS_DATA_W-1:0] bat_mv_q;
   logic [PCS_DATA_W-1:0] chg_ma_q;

   // synchronised pins
   logic [2:0] pins_raw;
   logic [2:0] pins_s;
   logic req_s;
   logic main_s;
   logic wdog_s;
   logic req_prev_q;
   logic req_rise;

   // sequencer
   pcs_state_type state_q;
   pcs_state_type state_d;
   logic [PCS_DATA_W-1:0] sec_q;
   logic on_batt_q;
   logic tick;
   logic restart_tick;
   logic arm_mode;
   logic up_always;
   logic wait_done;
   logic off_done;
   logic up_ready;

   assign pins_raw = {watchdog_enable, main_power_present,
                      shutdown_request_line};

   pcs_sync #(
      .WIDTH(3)
   ) u_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .async_in(pins_raw),
      .sync_out(pins_s)
   );

   assign req_s = pins_s[0];
   assign main_s = pins_s[1];
   assign wdog_s = pins_s[2];

   // interval timing restarts on state change and while main is absent
   // in power-up wait, so the up delay counts whole seconds of main power
   assign restart_tick = (state_d != state_q)
                         || (state_q == PCS_S_UP && !main_s);

   pcs_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .restart(restart_tick),
      .tick(tick)
   );

   assign arm_mode = mode_q[PCS_MODE_ARM_BIT];
   assign up_always = mode_q[PCS_MODE_UPALW_BIT];

   // request edge, from the host's shutdown line
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         req_prev_q <= 1'b0;
      end
      else
      begin
         req_prev_q <= req_s;
      end
   end

   assign req_rise = req_s && !req_prev_q;

   // register writes
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         mode_q <= PCS_MODE_RST;
         wait_s_q <= PCS_WAIT_RST;
         off_s_q <= PCS_OFF_RST;
         updly_s_q <= PCS_UPDLY_RST;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            PCS_IDX_MODE: mode_q <= reg_wdata
               & {14'h0000, PCS_MODE_MASK};
            PCS_IDX_WAIT: wait_s_q <= reg_wdata;
            PCS_IDX_OFF: off_s_q <= reg_wdata;
            PCS_IDX_UPDLY: updly_s_q <= reg_wdata;
            default:
            begin
            end
         endcase
      end
   end

   // monitor readings sampled every cycle
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         in_mv_q <= PCS_ZERO;
         in_ma_q <= PCS_ZERO;
         bat_mv_q <= PCS_ZERO;
         chg_ma_q <= PCS_ZERO;
      end
      else
      begin
         in_mv_q <= input_mv;
         in_ma_q <= input_ma;
         bat_mv_q <= battery_mv;
         chg_ma_q <= charge_ma;
      end
   end

   // register reads, data one cycle after the strobe
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         reg_rdata <= PCS_ZERO;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
         begin
            case (reg_addr)
               PCS_IDX_MODE: reg_rdata <= mode_q;
               PCS_IDX_WAIT: reg_rdata <= wait_s_q;
               PCS_IDX_OFF: reg_rdata <= off_s_q;
               PCS_IDX_UPDLY: reg_rdata <= updly_s_q;
               PCS_IDX_IN_MV: reg_rdata <= in_mv_q;
               PCS_IDX_IN_MA: reg_rdata <= in_ma_q;
               PCS_IDX_BAT_MV: reg_rdata <= bat_mv_q;
               PCS_IDX_CHG_MA: reg_rdata <= chg_ma_q;
               default: reg_rdata <= PCS_ZERO;
            endcase
         end
      end
   end

   // interval complete checks
   assign wait_done = (sec_q >= wait_s_q);
   assign off_done = (sec_q >= off_s_q);
   assign up_ready = main_s && ((updly_s_q == PCS_ZERO)
                     || (sec_q >= updly_s_q));

   // sequencer next state
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         PCS_S_UP:
         begin
            if (up_ready)
            begin
               state_d = PCS_S_IDLE;
            end
         end
         PCS_S_IDLE:
         begin
            if (req_rise)
            begin
               if (arm_mode)
               begin
                  state_d = PCS_S_ARMED;
               end
               else
               begin
                  state_d = PCS_S_WAIT;
               end
            end
         end
         PCS_S_ARMED:
         begin
            if (!req_s)
            begin
               state_d = PCS_S_WAIT;
            end
         end
         PCS_S_WAIT:
         begin
            if (wait_done)
            begin
               state_d = PCS_S_OFF;
            end
         end
         PCS_S_OFF:
         begin
            if (off_done)
            begin
               if (up_always)
               begin
                  state_d = PCS_S_IDLE;
               end
               else
               begin
                  state_d = PCS_S_UP;
               end
            end
         end
         default:
         begin
            state_d = PCS_S_UP;
         end
      endcase
   end

   // state register; start fully off until main power proves present
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         state_q <= PCS_S_UP;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // whole seconds in the current state; cleared with the tick restart
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         sec_q <= PCS_ZERO;
      end
      else if (restart_tick)
      begin
         sec_q <= PCS_ZERO;
      end
      else if (tick && sec_q != {PCS_DATA_W{1'b1}})
      begin
         sec_q <= sec_q + PCS_ONE;
      end
   end

   // battery condition caught when the countdown begins
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         on_batt_q <= 1'b0;
      end
      else if (state_q != PCS_S_WAIT && state_d == PCS_S_WAIT)
      begin
         on_batt_q <= !main_s;
      end
      else if (state_d == PCS_S_IDLE)
      begin
         on_batt_q <= 1'b0;
      end
   end

   // power outputs follow the next state so they change with it
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         host_power_en <= 1'b0;
         host_run <= 1'b0;
         usb_power_en <= 1'b0;
         unit_power_en <= 1'b0;
         cycle_active <= 1'b0;
      end
      else
      begin
         host_power_en <= (state_d == PCS_S_IDLE) || (state_d == PCS_S_ARMED)
                          || (state_d == PCS_S_WAIT);
         host_run <= (state_d == PCS_S_IDLE) || (state_d == PCS_S_ARMED)
                     || (state_d == PCS_S_WAIT);
         usb_power_en <= (state_d == PCS_S_IDLE)
                         || (state_d == PCS_S_ARMED)
                         || (state_d == PCS_S_WAIT);
         if (state_d == PCS_S_OFF && on_batt_q && !up_always)
         begin
            unit_power_en <= 1'b0;
         end
         else if (state_d == PCS_S_UP)
         begin
            unit_power_en <= unit_power_en && !on_batt_q && main_s;
         end
         else
         begin
            unit_power_en <= 1'b1;
         end
         cycle_active <= (state_d == PCS_S_WAIT) || (state_d == PCS_S_OFF);
      end
   end

   // keep watchdog supervising while armed line is high
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         watchdog_hold <= 1'b0;
      end
      else
      begin
         watchdog_hold <= wdog_s && arm_mode && req_s;
      end
   end

endmodule : pcs_top

// ===== verif/pcs_host_model.sv
// host side model that drives the shutdown request line
module pcs_host_model
(
   input wire logic core_clk,
   input wire logic want_down,
   output logic shutdown_request_line
);
   timeunit 1ns;
   timeprecision 100ps;
   // software power-down enable, the pin follows one edge later
   always @(posedge core_clk)
   begin
      shutdown_request_line <= want_down;
   end
endmodule : pcs_host_model

// ===== verif/pcs_top_chk.sv
// port checker for the power cycle sequencer
module pcs_chk
   import pcs_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = PCS_TICK_CYCLES
)
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic shutdown_request_line,
   input wire logic main_power_present,
   input wire logic watchdog_enable,
   input wire logic [PCS_ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [PCS_DATA_W-1:0] reg_wdata,
   input wire logic [PCS_DATA_W-1:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic [PCS_DATA_W-1:0] input_mv,
   input wire logic [PCS_DATA_W-1:0] input_ma,
   input wire logic [PCS_DATA_W-1:0] battery_mv,
   input wire logic [PCS_DATA_W-1:0] charge_ma,
   input wire logic host_power_en,
   input wire logic host_run,
   input wire logic usb_power_en,
   input wire logic unit_power_en,
   input wire logic watchdog_hold,
   input wire logic cycle_active
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   rd_answer_a: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered next cycle");
   rvalid_pulse_a: assert property (!reg_rd |=> !reg_rvalid)
      else $error("read valid without a read");
   rdata_hold_a: assert property (!reg_rvalid |-> $stable(reg_rdata))
      else $error("read data moved without a read");
   run_follows_a: assert property (host_run == host_power_en)
      else $error("run line differs from host power");
   usb_off_a: assert property (!host_power_en |-> !usb_power_en)
      else $error("usb powered while host is off");
   start_cause_a: assert property ($rose(cycle_active) |->
      $past(shutdown_request_line, 2) != $past(shutdown_request_line, 6))
      else $error("cycle started without a request edge");
   start_up_a: assert property ($rose(cycle_active) |->
      host_power_en && unit_power_en)
      else $error("cycle started while unpowered");
   host_drop_a: assert property ($fell(host_power_en) |-> cycle_active)
      else $error("host power dropped outside a cycle");
   wdog_hold_a: assert property (watchdog_hold |->
      $past(watchdog_enable, 3) && $past(shutdown_request_line, 3))
      else $error("watchdog hold without cause");
   unit_rise_a: assert property ($rose(unit_power_en) |->
      $past(main_power_present, 2))
      else $error("unit powered up without main power");
endmodule : pcs_chk

bind pcs_top pcs_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_i (.core_clk, .rst_b,
   .shutdown_request_line, .main_power_present, .watchdog_enable, .reg_addr,
   .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .input_mv,
   .input_ma, .battery_mv, .charge_ma, .host_power_en, .host_run,
   .usb_power_en, .unit_power_en, .watchdog_hold, .cycle_active);

// ===== verif/tb_power_cycle_sequencer.sv
// self-checking bench for the power cycle sequencer
module tb_power_cycle_sequencer import pcs_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TK = 4;
   logic core_clk = 1'b0, rst_b = 1'b0, main_power_present = 1'b1;
   logic watchdog_enable = 1'b0, want = 1'b0, shutdown_request_line;
   logic reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   logic [15:0] input_mv = 16'h5DC0, input_ma = 16'h00FA;
   logic [15:0] battery_mv = 16'h3200, charge_ma = 16'h0064;
   logic host_power_en, host_run, usb_power_en, unit_power_en;
   logic watchdog_hold, cycle_active;
   int bad_count = 0, cmp_count = 0, cyc = 0, n;
   pcs_top #(.TICK_CYCLES(TK)) uut (.core_clk, .rst_b, .shutdown_request_line,
      .main_power_present, .watchdog_enable, .reg_addr, .reg_wr, .reg_rd,
      .reg_wdata, .reg_rdata, .reg_rvalid, .input_mv, .input_ma, .battery_mv,
      .charge_ma, .host_power_en, .host_run, .usb_power_en, .unit_power_en,
      .watchdog_hold, .cycle_active);
   pcs_host_model host_i (.core_clk, .want_down(want), .shutdown_request_line);
   initial
   begin
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         bad_count++;
         results();
      end
   end
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      cmp_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      chk("read valid", {15'h0, reg_rvalid}, 16'h0001);
      chk($sformatf("register %h", a), reg_rdata, exp);
   endtask : rchk
   // cycles until host power (0), cycle (1) or unit power (2) reach lvl
   task automatic upto(input int sel, input logic lvl, output int k);
      logic s;
      k = 0;
      do
      begin
         @(posedge core_clk);
         k++;
         s = sel == 0 ? host_power_en : sel == 1 ? cycle_active : unit_power_en;
      end
      while (s !== lvl && k < 300);
   endtask : upto
   task automatic span(input string nm, input int lo, hi);
      chk(nm, {15'h0, n >= lo && n <= hi}, 16'h0001);
   endtask : span
   initial
   begin
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      rchk(PCS_IDX_MODE, 16'h0000);
      rchk(PCS_IDX_WAIT, 16'h003C);
      rchk(PCS_IDX_OFF, 16'h0005);
      rchk(PCS_IDX_UPDLY, 16'h0000);
      rchk(8'h30, 16'h0000);
      wr(PCS_IDX_MODE, 16'hFFFF);
      rchk(PCS_IDX_MODE, 16'h0003);
      wr(PCS_IDX_IN_MV, 16'h1234);
      rchk(PCS_IDX_IN_MV, 16'h5DC0);
      rchk(PCS_IDX_IN_MA, 16'h00FA);
      rchk(PCS_IDX_BAT_MV, 16'h3200);
      rchk(PCS_IDX_CHG_MA, 16'h0064);
      wr(PCS_IDX_WAIT, 16'h0002);
      wr(PCS_IDX_OFF, 16'h0001);
      wr(PCS_IDX_MODE, 16'h0000);
      chk("host powered", {15'h0, host_power_en}, 16'h0001);
      want <= 1'b1;
      upto(1, 1'b1, n);
      span("default start", 2, 6);
      upto(0, 1'b0, n);
      span("wait time", 2 * TK - 1, 2 * TK + 3);
      chk("usb off", {15'h0, usb_power_en}, 16'h0000);
      chk("run low", {15'h0, host_run}, 16'h0000);
      chk("unit kept", {15'h0, unit_power_en}, 16'h0001);
      upto(0, 1'b1, n);
      span("off time", TK, TK + 4);
      want <= 1'b0;
      wr(PCS_IDX_MODE, 16'h0001);
      watchdog_enable <= 1'b1;
      want <= 1'b1;
      repeat (20) @(posedge core_clk);
      chk("armed idle", {15'h0, cycle_active}, 16'h0000);
      chk("hold armed", {15'h0, watchdog_hold}, 16'h0001);
      want <= 1'b0;
      upto(1, 1'b1, n);
      span("arm start", 2, 6);
      chk("hold released", {15'h0, watchdog_hold}, 16'h0000);
      upto(0, 1'b0, n);
      span("arm wait", 2 * TK - 1, 2 * TK + 3);
      upto(0, 1'b1, n);
      span("arm off", TK, TK + 4);
      wr(PCS_IDX_UPDLY, 16'h0002);
      wr(PCS_IDX_MODE, 16'h0000);
      main_power_present <= 1'b0;
      repeat (4) @(posedge core_clk);
      want <= 1'b1;
      upto(0, 1'b0, n);
      span("batt wait", 2 * TK + 3, 2 * TK + 9);
      repeat (2) @(posedge core_clk);
      chk("unit off", {15'h0, unit_power_en}, 16'h0000);
      repeat (40) @(posedge core_clk);
      chk("stay off", {15'h0, host_power_en}, 16'h0000);
      main_power_present <= 1'b1;
      want <= 1'b0;
      upto(0, 1'b1, n);
      span("up delay", 2 * TK, 2 * TK + 6);
      chk("unit back", {15'h0, unit_power_en}, 16'h0001);
      wr(PCS_IDX_MODE, 16'h0002);
      main_power_present <= 1'b0;
      want <= 1'b1;
      upto(0, 1'b0, n);
      span("host only wait", 2 * TK + 3, 2 * TK + 9);
      upto(0, 1'b1, n);
      span("battery off", TK, TK + 4);
      chk("unit on", {15'h0, unit_power_en}, 16'h0001);
      results();
   end
endmodule : tb_power_cycle_sequencer
